// ===== design/dual_timer_pkg.sv
// Shared constants for the dual interval and pulse timer
package dual_timer_pkg;

	// Clock and time base derivation
	localparam int CLK_PERIOD_NS = 50;
	localparam int US_NS         = 1000;
	localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
	localparam int TB_COUNT      = 4;
	localparam int TB_US [TB_COUNT] = '{1, 5, 25, 50};

	// Sizes
	localparam int NUM_TIMERS = 2;
	localparam int CNT_W      = 16;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;

	// Register byte offsets; address bit 2 picks the timer
	localparam logic [7:0] OFF_COUNT  = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h08;
	localparam logic [7:0] OFF_MODE   = 8'h10;
	localparam logic [7:0] OFF_CMD    = 8'h18;
	localparam logic [7:0] OFF_PREP   = 8'h20;
	localparam logic [7:0] OFF_STAT   = 8'h28;
	localparam int         SEL_BIT    = 2;

	// Mode word fields
	localparam int MODE_GATE_BIT     = 15;
	localparam int MODE_EXT_BIT      = 14;
	localparam int MODE_PERIODIC_BIT = 2;
	localparam int MODE_TB_LSB       = 0;

	// Command word fields
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT  = 1;
	localparam int CMD_RUN_BIT   = 0;
	localparam int CMD_GATE_BIT  = 1;
	localparam int CMD_GATEN_BIT = 2;

	// Status and mask layout: underflow at bit i, gate end at bit 2+i
	localparam int STAT_UNDER_LSB = 0;
	localparam int STAT_END_LSB   = 2;
	localparam int STAT_W         = 4;

	// Reset and wrap values
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] MODE_RST   = 16'h0000;
	localparam logic [3:0]  STAT_RST   = 4'h0;
	localparam logic [3:0]  MASK_RST   = 4'h0;
	localparam logic [15:0] COUNT_WRAP = 16'hffff;

endpackage

// ===== design/timer_ctl_if.sv
// Control and state bundle between the top and one count unit
`timescale 1ns/10ps
interface timer_ctl_if;
	logic        wrCount;
	logic        wrReload;
	logic        wrMode;
	logic        step;
	logic [15:0] wdata;
	logic [15:0] count;
	logic [15:0] reload;
	logic [15:0] mode;
	logic        underflow;

	modport ctrl (
		output wrCount, wrReload, wrMode, step, wdata,
		input  count, reload, mode, underflow
	);
	modport unit (
		input  wrCount, wrReload, wrMode, step, wdata,
		output count, reload, mode, underflow
	);
endinterface

// ===== design/timer_count_unit.sv
// One 16-bit down counter with auto-load and mode word
`timescale 1ns/10ps
module timer_count_unit (
	input wire logic    clk,
	input wire logic    srst,
	timer_ctl_if.unit   ctl
);
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [15:0] mode_q;
	logic        atZero;

	assign atZero        = (count_q == 16'h0000);
	assign ctl.count     = count_q;
	assign ctl.reload    = reload_q;
	assign ctl.mode      = mode_q;
	// Zero decremented is the underflow, so N gives N+1 periods
	assign ctl.underflow = ctl.step & ~ctl.wrCount & atZero;

	// Load wins over a step; the host stops the timer before loading
	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= dual_timer_pkg::COUNT_RST;
		end else if (ctl.wrCount) begin
			count_q <= ctl.wdata;
		end else if (ctl.step) begin
			if (atZero) begin
				if (mode_q[dual_timer_pkg::MODE_PERIODIC_BIT]) begin
					count_q <= reload_q;
				end else begin
					count_q <= dual_timer_pkg::COUNT_WRAP;
				end
			end else begin
				count_q <= count_q - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reload_q <= dual_timer_pkg::RELOAD_RST;
		end else if (ctl.wrReload) begin
			reload_q <= ctl.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q <= dual_timer_pkg::MODE_RST;
		end else if (ctl.wrMode) begin
			mode_q <= ctl.wdata;
		end
	end
endmodule

// ===== design/dual_interval_pulse_timer.sv
// Two-timer card: APB registers, time bases, run and gate control
//
// Behaviour
// - Two independent 16-bit counters for intervals, pulse counts, durations.
// - Each timer is started, stopped, read and loaded on its own.
// - Reading a count changes neither the count nor the run state.
// - Mode picks internal base or external clock; one decrement per period.
// - Internal bases are 1, 5, 25 and 50 microseconds.
// - Mode word also holds the external gate enable.
// - Periodic or aperiodic, each internal or gate controlled.
// - Periodic mode reloads from the auto-load register and interrupts.
// - Aperiodic mode interrupts, then wraps for a full 65,536 counts.
// - Gate mode counts only while the gate input is active.
// - Per timer: run and gate enable outputs, clock and gate inputs.
// - Run goes on at start, off at stop, gate drop or reset.
// - Address bit picks the timer, except for prepare and status.
// - Mode bit 15 enables the gate, bit 14 picks external base.
// - External clock counted once at its active edge, even across restarts.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
module dual_interval_pulse_timer (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  extClkN,
	input  wire logic [1:0]  extGateN,
	output logic      [1:0]  runN,
	output logic      [1:0]  gateEnN,
	output logic             irq
);

	// Word compare on the register group; bit 2 selects the timer
	function automatic logic regHit(input logic [7:0] addr,
		input logic [7:0] base);
		regHit = (addr[7:3] == base[7:3]);
	endfunction

	// Bus side
	logic        setupPh;
	logic        wrAcc;
	logic        selT;
	logic        mapped;
	logic [31:0] rdMux;
	logic [31:0] prdata_q;
	logic        pslverr_q;

	// Time base
	logic [4:0]  usCnt_q;
	logic        usTick;
	logic [3:0]  tbTick;

	// Per timer state
	logic [1:0]  running_q;
	logic [1:0]  running_d;
	logic [1:0]  clkPrev_q;
	logic [1:0]  gatePrev_q;
	logic [1:0]  runN_q;
	logic [1:0]  gateEnN_q;
	logic [1:0]  startCmd;
	logic [1:0]  stopCmd;
	logic [1:0]  gateEnd;
	logic [1:0]  underV;
	logic [15:0] countV  [2];
	logic [15:0] reloadV [2];
	logic [15:0] modeV   [2];

	// Interrupt state
	logic [3:0]  stat_q;
	logic [3:0]  stat_d;
	logic [3:0]  mask_q;
	logic [3:0]  mask_d;
	logic [3:0]  statSet;
	logic [3:0]  statClr;
	logic        irq_q;

	// One control bundle per count unit
	timer_ctl_if ctl [2] ();

	// APB decode; zero wait states, data staged at setup
	assign setupPh = psel & ~penable;
	assign wrAcc   = psel & penable & pwrite;
	assign selT    = paddr[dual_timer_pkg::SEL_BIT];
	assign mapped  = regHit(paddr, dual_timer_pkg::OFF_COUNT)
		| regHit(paddr, dual_timer_pkg::OFF_RELOAD)
		| regHit(paddr, dual_timer_pkg::OFF_MODE)
		| regHit(paddr, dual_timer_pkg::OFF_CMD)
		| regHit(paddr, dual_timer_pkg::OFF_PREP)
		| regHit(paddr, dual_timer_pkg::OFF_STAT);
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// Pure read path: no side effects on count or run state
	always_comb begin
		rdMux = 32'h0000_0000;
		if (regHit(paddr, dual_timer_pkg::OFF_COUNT)) begin
			rdMux[15:0] = countV[selT];
		end else if (regHit(paddr, dual_timer_pkg::OFF_RELOAD)) begin
			rdMux[15:0] = reloadV[selT];
		end else if (regHit(paddr, dual_timer_pkg::OFF_MODE)) begin
			rdMux[15:0] = modeV[selT];
		end else if (regHit(paddr, dual_timer_pkg::OFF_CMD)) begin
			rdMux[dual_timer_pkg::CMD_RUN_BIT]   = running_q[selT];
			rdMux[dual_timer_pkg::CMD_GATE_BIT]  = ~extGateN[selT];
			rdMux[dual_timer_pkg::CMD_GATEN_BIT] =
				modeV[selT][dual_timer_pkg::MODE_GATE_BIT];
		end else if (regHit(paddr, dual_timer_pkg::OFF_PREP)) begin
			rdMux[3:0] = mask_q;
		end else if (regHit(paddr, dual_timer_pkg::OFF_STAT)) begin
			rdMux[3:0] = stat_q;
		end
	end

	// Staged at setup so it stands through the access phase
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_q <= 32'h0000_0000;
		end else if (setupPh) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
		end
	end

	// Unmapped words answer with an error, writes there are dropped
	always_ff @(posedge clk) begin
		if (srst) begin
			pslverr_q <= 1'b0;
		end else if (setupPh) begin
			pslverr_q <= ~mapped;
		end
	end

	// Microsecond prescaler feeding all internal bases
	assign usTick = (usCnt_q == 5'(dual_timer_pkg::US_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (srst) begin
			usCnt_q <= 5'h00;
		end else if (usTick) begin
			usCnt_q <= 5'h00;
		end else begin
			usCnt_q <= usCnt_q + 5'h01;
		end
	end

	// The 1 us base is the prescaler tick itself
	assign tbTick[0] = usTick;

	// Bases share the microsecond tick, so they stay phase related
	genvar b;
	generate
		for (b = 1; b < dual_timer_pkg::TB_COUNT; b++) begin : g_base
			localparam logic [5:0] DIV_LAST = 6'(
				dual_timer_pkg::TB_US[b] / dual_timer_pkg::TB_US[0] - 1);
			logic [5:0] divCnt_q;
			assign tbTick[b] = usTick & (divCnt_q == DIV_LAST);
			always_ff @(posedge clk) begin
				if (srst) begin
					divCnt_q <= 6'h00;
				end else if (usTick) begin
					divCnt_q <= (divCnt_q == DIV_LAST) ? 6'h00
						: divCnt_q + 6'h01;
				end
			end
		end
	endgenerate

	// Per timer control path
	genvar t;
	generate
		for (t = 0; t < dual_timer_pkg::NUM_TIMERS; t++) begin : g_tmr
			logic       clkAct;
			logic       gateAct;
			logic       clkEdge;
			logic       gateEn;
			logic       extBase;
			logic       baseTick;
			logic       hitT;
			logic       cmdHit;
			logic [1:0] tbSel;

			assign hitT    = wrAcc & (selT == 1'(t));
			assign clkAct  = ~extClkN[t];
			assign gateAct = ~extGateN[t];
			assign gateEn  = modeV[t][dual_timer_pkg::MODE_GATE_BIT];
			assign extBase = modeV[t][dual_timer_pkg::MODE_EXT_BIT];
			assign tbSel   = modeV[t][dual_timer_pkg::MODE_TB_LSB +: 2];

			// Edge seen regardless of run state, so a held pulse counts once
			assign clkEdge = clkAct & ~clkPrev_q[t];

			always_ff @(posedge clk) begin
				if (srst) begin
					clkPrev_q[t] <= 1'b0;
				end else begin
					clkPrev_q[t] <= clkAct;
				end
			end

			// Last gate level, for the drop that ends a gated run
			always_ff @(posedge clk) begin
				if (srst) begin
					gatePrev_q[t] <= 1'b0;
				end else begin
					gatePrev_q[t] <= gateAct;
				end
			end

			// External edge or a shared internal tick, per mode
			assign baseTick = extBase ? clkEdge : tbTick[tbSel];

			// Command word of this timer; stop and start bits
			assign cmdHit      = hitT
				& regHit(paddr, dual_timer_pkg::OFF_CMD);
			assign startCmd[t] = cmdHit
				& pwdata[dual_timer_pkg::CMD_START_BIT];
			assign stopCmd[t]  = cmdHit
				& pwdata[dual_timer_pkg::CMD_STOP_BIT];

			// Gate going inactive ends the run in gate mode
			assign gateEnd[t] = running_q[t] & gateEn
				& gatePrev_q[t] & ~gateAct;

			// Stop has priority when both command bits are set
			always_comb begin
				running_d[t] = running_q[t];
				if (stopCmd[t]) begin
					running_d[t] = 1'b0;
				end else if (startCmd[t]) begin
					running_d[t] = 1'b1;
				end else if (gateEnd[t]) begin
					running_d[t] = 1'b0;
				end
			end

			// Reset ends the run like a stop
			always_ff @(posedge clk) begin
				if (srst) begin
					running_q[t] <= 1'b0;
				end else begin
					running_q[t] <= running_d[t];
				end
			end

			// Active-low pins, registered so they are glitch free
			always_ff @(posedge clk) begin
				if (srst) begin
					runN_q[t] <= 1'b1;
				end else begin
					runN_q[t] <= ~running_d[t];
				end
			end

			// Follows mode bit 15 even while the timer is stopped
			always_ff @(posedge clk) begin
				if (srst) begin
					gateEnN_q[t] <= 1'b1;
				end else begin
					gateEnN_q[t] <= ~gateEn;
				end
			end

			assign ctl[t].wrCount  = hitT
				& regHit(paddr, dual_timer_pkg::OFF_COUNT);
			assign ctl[t].wrReload = hitT
				& regHit(paddr, dual_timer_pkg::OFF_RELOAD);
			assign ctl[t].wrMode   = hitT
				& regHit(paddr, dual_timer_pkg::OFF_MODE);
			assign ctl[t].wdata    = pwdata[15:0];
			// Gate mode counts only while the gate is held active
			assign ctl[t].step     = running_q[t] & baseTick
				& (~gateEn | gateAct);

			// Unit state for the read mux and the status word
			assign countV[t]  = ctl[t].count;
			assign reloadV[t] = ctl[t].reload;
			assign modeV[t]   = ctl[t].mode;
			assign underV[t]  = ctl[t].underflow;

			// Each unit owns its count, auto-load and mode words
			timer_count_unit u_unit (
				.clk  (clk),
				.srst (srst),
				.ctl  (ctl[t])
			);
		end
	endgenerate

	// Pins idle high out of reset, as inactive levels
	assign runN    = runN_q;
	assign gateEnN = gateEnN_q;

	// Sticky status; a new event in the clearing cycle survives
	always_comb begin
		statSet = 4'h0;
		statSet[dual_timer_pkg::STAT_UNDER_LSB +: 2] = underV;
		statSet[dual_timer_pkg::STAT_END_LSB +: 2]   = gateEnd;
	end
	assign statClr = (wrAcc & regHit(paddr, dual_timer_pkg::OFF_STAT))
		? pwdata[3:0] : 4'h0;
	assign stat_d  = (stat_q & ~statClr) | statSet;

	always_ff @(posedge clk) begin
		if (srst) begin
			stat_q <= dual_timer_pkg::STAT_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	// Prepare word is shared by both timers, address bit ignored
	assign mask_d = (wrAcc & regHit(paddr, dual_timer_pkg::OFF_PREP))
		? pwdata[3:0] : mask_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_q <= dual_timer_pkg::MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Next-state mask too, so irq follows a prepare write with no lag
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_d & mask_d);
		end
	end

	assign irq = irq_q;

endmodule

// ===== sim/dual_interval_pulse_timer_asserts.sv
// Port-level assertions for the dual timer
`timescale 1ns/10ps
module dual_interval_pulse_timer_asserts (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  extClkN,
	input wire logic [1:0]  extGateN,
	input wire logic [1:0]  runN,
	input wire logic [1:0]  gateEnN,
	input wire logic        irq
);
	logic wa;
	assign wa = psel && penable && pwrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_reset_idle: assert property (disable iff (1'h0)
		srst |=> runN == 2'h3 && gateEnN == 2'h3 && !irq)
		else $error("Outputs busy after reset");
	a_start_zero: assert property (
		wa && paddr == 8'h18 && pwdata[1:0] == 2'h1 |=> !runN[0])
		else $error("Timer 0 not started");
	a_start_one: assert property (
		wa && paddr == 8'h1c && pwdata[1:0] == 2'h1 |=> !runN[1])
		else $error("Timer 1 not started");
	a_stop_wins: assert property (
		wa && paddr == 8'h18 && pwdata[1] |=> runN[0])
		else $error("Timer 0 not stopped");
	a_run_cause: assert property (
		$fell(runN[0]) |-> $past(wa && paddr == 8'h18 && pwdata[0]))
		else $error("Run without start");
	a_gate_flag: assert property (
		wa && paddr == 8'h10 |=> ##1 gateEnN[0] == !$past(pwdata[15], 2))
		else $error("Gate enable pin wrong");
	a_read_keeps: assert property (
		psel && penable && !pwrite && paddr < 8'h08 |=> runN == $past(runN))
		else $error("Count read moved run");
	a_gate_stop: assert property (
		!runN[0] && !gateEnN[0] && $rose(extGateN[0]) |-> ##[1:3] runN[0])
		else $error("Gate end left timer running");
	c_irq: cover property ($rose(irq));
	c_gate_end: cover property ($rose(runN[0]) && !gateEnN[0]);
	c_error: cover property (pslverr);
endmodule

bind dual_interval_pulse_timer dual_interval_pulse_timer_asserts
	dual_interval_pulse_timer_asserts_inst (.*);

// ===== sim/ext_signal_source.sv
// Customer clock and gate source facing both timers
`timescale 1ns/10ps
module ext_signal_source (
	input  wire logic       clk,
	input  wire logic [1:0] clkOn,
	input  wire logic [1:0] gateOn,
	output logic      [1:0] extClkN,
	output logic      [1:0] extGateN,
	output int              pulses
);
	int         phase = 0;
	logic [1:0] on = 2'h0;
	initial begin
		extClkN = 2'h3;
		extGateN = 2'h3;
		pulses = 0;
	end
	// Pulses begin only at a period start, so none is cut short
	always @(posedge clk) begin
		phase <= (phase + 1) % 40;
		extGateN <= ~gateOn;
		extClkN <= ~(on & {2{phase > 0 && phase <= 20}});
		if (phase == 0) begin
			on <= clkOn;
			pulses <= clkOn[1] ? pulses + 1 : 0;
		end
	end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the dual timer
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [32:0] v; logic [32:0] m;} exp_t;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic [7:0]  paddr = 8'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  extClkN;
	logic [1:0]  extGateN;
	logic [1:0]  runN;
	logic [1:0]  gateEnN;
	logic        irq;
	logic [1:0]  clkOn = 2'h0;
	logic [1:0]  gateOn = 2'h0;
	int          pulses;
	int          failCount = 0;
	int          comparisons = 0;
	exp_t        expQ[$];
	realtime     t0;

	always #25 clk = ~clk;
	dual_interval_pulse_timer dual_interval_pulse_timer_inst (.*);
	ext_signal_source ext_signal_source_inst (.*);

	task automatic check(input logic ok, input string s);
		comparisons++;
		if (ok !== 1'h1) begin
			failCount++;
			$display("CHECK FAILED at %0t: %s", $time, s);
		end
	endtask
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic hang;
		check(1'h0, "timeout");
		summarize();
	endtask
	// Reads leave their expectation for the monitor below
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d, input exp_t e);
		int n;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		if (!w)
			expQ.push_back(e);
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n == 50)
			hang();
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'h1, d, '{33'h0, 33'h0});
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] v,
			input logic [32:0] m = 33'h1ffffffff);
		apb(a, 1'h0, 32'h0, '{v, m});
	endtask
	task automatic waitIrq;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (irq !== 1'h1 && n < 9000);
		if (n == 9000)
			hang();
	endtask

	always @(posedge clk) begin
		exp_t e;
		if (psel && penable && pready && !pwrite) begin
			e = expQ.pop_front();
			check(({pslverr, prdata} & e.m) === (e.v & e.m), "read value");
		end
	end

	initial begin
		int r;
		logic [7:0] o;
		realtime p;
		r = $urandom(75885);
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		@(negedge clk);
		check(runN === 2'h3 && gateEnN === 2'h3 && irq === 1'h0, "idle");
		rd(8'h28, 33'h0);
		rd(8'h30, 33'h100000000);
		wr(8'h20, 32'hf);
		rd(8'h24, 33'hf);
		for (int i = 0; i < 2; i++) begin
			o = i[0] ? 8'h04 : 8'h00;
			r = $urandom;
			wr(o, {16'h0, r[15:0]});
			wr(8'h08 | o, {16'h0, r[31:16]});
			wr(8'h10 | o, {16'h0, r[15:14], 11'h0, r[2:0]});
			rd(o, {17'h0, r[15:0]});
			rd(8'h08 | o, {17'h0, r[31:16]});
			rd(8'h10 | o, {17'h0, r[15:14], 11'h0, r[2:0]});
			@(negedge clk);
			check(gateEnN[i] === ~r[15] && runN === 2'h3, "mode pin");
			wr(8'h10 | o, 32'h0);
		end
		for (int b = 0; b < 4; b++) begin
			wr(8'h10, {30'h1, b[1:0]});
			wr(8'h08, 32'h1);
			wr(8'h00, 32'h1);
			wr(8'h18, 32'h1);
			rd(8'h00, 33'h0, 33'h1ffff0000);
			waitIrq();
			t0 = $realtime;
			wr(8'h28, 32'h1);
			waitIrq();
			p = 2.0 * dual_timer_pkg::US_NS * dual_timer_pkg::TB_US[b];
			check($realtime - t0 == p, "period");
			check(runN === 2'h2, "timer 1 idle");
			wr(8'h18, 32'h3);
			wr(8'h28, 32'h1);
		end
		wr(8'h0c, 32'h5);
		wr(8'h04, 32'h0);
		wr(8'h1c, 32'h1);
		waitIrq();
		rd(8'h04, 33'hffff);
		rd(8'h28, 33'h2);
		wr(8'h24, 32'h1);
		@(negedge clk);
		check(irq === 1'h0, "masked out");
		wr(8'h20, 32'hf);
		wr(8'h1c, 32'h2);
		wr(8'h28, 32'hf);
		wr(8'h14, 32'h4004);
		wr(8'h0c, 32'h2);
		wr(8'h04, 32'h2);
		wr(8'h1c, 32'h1);
		clkOn <= 2'h2;
		waitIrq();
		check(pulses == 3, "pulse count");
		clkOn <= 2'h0;
		wr(8'h1c, 32'h2);
		wr(8'h28, 32'hf);
		wr(8'h10, 32'h8000);
		wr(8'h00, 32'h3e8);
		wr(8'h18, 32'h1);
		repeat (200) @(posedge clk);
		rd(8'h00, 33'h3e8);
		rd(8'h18, 33'h5);
		gateOn <= 2'h1;
		repeat (400) @(posedge clk);
		gateOn <= 2'h0;
		repeat (4) @(negedge clk);
		check(runN === 2'h3 && irq === 1'h1, "gate end");
		rd(8'h00, 33'h3d0, 33'h1fff0);
		rd(8'h28, 33'h4);
		summarize();
	end
endmodule
